//--- verilog/cabinet_map.svh
`ifndef CABINET_MAP_SVH
`define CABINET_MAP_SVH
// ---------------------------------------------------------------
// timing base
// ---------------------------------------------------------------
`define CLK_NS          8
`define TICK_MS         100
`define TICK_CYCLES     (`TICK_MS * 1000000 / `CLK_NS)
`define TICKS_PER_S     10
`define S_PER_MIN       60
`define CNT_W           16
`define SYNC_W          3
`define SYNC_IDLE       3'h2    // {overheat, 24 v ok, mains}: only 24 v ok idles high
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define OFF_CTRL        8'h00
`define OFF_CFG         8'h04
`define OFF_START_T     8'h08
`define OFF_STOP_T      8'h0c
`define OFF_ON_DLY      8'h10
`define OFF_OFF_DLY     8'h14
`define OFF_DIS_STOP    8'h18
`define OFF_MAINS_TO    8'h1c
`define OFF_P24_DLY     8'h20
`define OFF_STATUS      8'h24
`define OFF_IRQ_STAT    8'h28
`define OFF_IRQ_CLR     8'h2c
`define OFF_IRQ_EN      8'h30
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_ACK        2
`define CFG_RESP_WARN   0
`define CFG_OH_LO       2
`define CFG_OH_HI       3
`define CFG_P24_WARN    4
`define EV_CLOSE_MISS   0
`define EV_OPEN_MISS    1
`define EV_P24_WARN     2
`define EV_P24_ERR      3
`define EV_OH_WARN      4
`define EV_OH_ERR       5
`define EV_W            6
// ---------------------------------------------------------------
// reset values, in their own units
// ---------------------------------------------------------------
`define PULSE_DEF_MS    500
`define DIS_STOP_DEF_MS 60000
`define MAINS_TO_DEF_S  5
`define P24_DLY_DEF_S   3
`define OH_WARN_MIN     10
`define OH_WARN_TICKS   (`OH_WARN_MIN * `S_PER_MIN * `TICKS_PER_S)
`endif

//--- verilog/cabinet_pkg.sv
`include "cabinet_map.svh"
package cabinet_pkg;
    typedef enum logic [2:0] {
        BRK_OPEN, BRK_START, BRK_CLOSE_WAIT, BRK_CLOSED, BRK_STOP, BRK_OPEN_WAIT
    } brk_state_t;

    typedef enum logic [1:0] {
        OH_IGNORE, OH_WARN, OH_STOP, OH_WARN_STOP
    } oh_mode_t;

    typedef struct packed {
        logic [31:0] cnt;
        logic        tick;
    } presc_t;

    typedef struct packed {
        logic [`SYNC_W-1:0] meta;
        logic [`SYNC_W-1:0] sync;
    } sync_t;

    typedef struct packed {
        brk_state_t          state;
        logic                start_pulse;
        logic                stop_pulse;
        logic                start_req;
        logic                stop_req;
        logic [`CNT_W-1:0]   pulse_cnt;
        logic [`CNT_W-1:0]   since_start;
        logic [`CNT_W-1:0]   since_stop;
        logic [`CNT_W-1:0]   mon_cnt;
        logic [`CNT_W-1:0]   p24_cnt;
        logic [`CNT_W-1:0]   oh_cnt;
        logic                close_missing;
        logic                open_missing;
        logic                halt_inhibited;
        logic                app_stop;
        logic                run_en;
        logic                warn;
        logic                p24_lost;
        logic                p24_done;
        logic                oh_seen;
        logic                oh_done;
        logic                resp_warn;
        oh_mode_t            oh_mode;
        logic                p24_warn_only;
        logic [`CNT_W-1:0]   start_t;
        logic [`CNT_W-1:0]   stop_t;
        logic [`CNT_W-1:0]   on_dly;
        logic [`CNT_W-1:0]   off_dly;
        logic [`CNT_W-1:0]   dis_stop;
        logic [`CNT_W-1:0]   mains_to;
        logic [`CNT_W-1:0]   p24_dly;
        logic [`EV_W-1:0]    irq_stat;
        logic [`EV_W-1:0]    irq_en;
        logic                irq;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } sup_state_t;
endpackage

//--- verilog/tick_prescaler.sv
`timescale 1ns/10ps
`default_nettype none
`include "cabinet_map.svh"
module tick_prescaler
    import cabinet_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic core_clk_in,
    input  wire logic resetn_in,
    output var  logic tick_out
);
    presc_t st_ff;
    presc_t nxt_st;

    // free-running divider, one pulse per tick period
    always_comb begin
        nxt_st.cnt  = st_ff.cnt + 32'h0000_0001;
        nxt_st.tick = 1'b0;
        if (st_ff.cnt >= TICK_CYCLES - 1) begin
            nxt_st.cnt  = 32'h0000_0000;
            nxt_st.tick = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tick_out = st_ff.tick;
endmodule
`default_nettype wire

//--- verilog/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
`include "cabinet_map.svh"
module pin_sync
    import cabinet_pkg::*;
(
    input  wire logic              core_clk_in,
    input  wire logic              resetn_in,
    input  wire logic [`SYNC_W-1:0] pins_in,
    output var  logic [`SYNC_W-1:0] pins_out
);
    sync_t st_ff;
    sync_t nxt_st;

    // the first stage feeds only the second stage
    always_comb begin
        nxt_st.meta = pins_in;
        nxt_st.sync = st_ff.meta;
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_ff <= '{meta: `SYNC_IDLE, sync: `SYNC_IDLE};  // idle levels: no false loss at reset
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pins_out = st_ff.sync;
endmodule
`default_nettype wire

//--- verilog/breaker_cabinet_supervisor.sv
// Operation
// - stop pulse waits switch-on delay after start
// - start pulse waits switch-off delay after stop
// - pulse times and delays programmable, default 0.5s
// - disable-stop delay programmable, default 60.0s
// - report stop-disabled until that delay expires
// - mains monitoring timeout in seconds, default 5s
// - no voltage after start: fault, not-closed
// - voltage remains after stop: fault, not-open
// - breaker fault response error or warning
// - 24V loss warns now, errors after delay
// - overheat response ignore, warn, error, both
// - warn-then-error: warning ten minutes, then error
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "cabinet_map.svh"
module breaker_cabinet_supervisor
    import cabinet_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = `TICK_CYCLES
) (
    input  wire logic        core_clk_in,
    input  wire logic        resetn_in,
    // apb slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output var  logic [31:0] prdata_out,
    output var  logic        pready_out,
    output var  logic        pslverr_out,
    // cabinet pins
    input  wire logic        mains_present_in,
    input  wire logic        cab_24v_ok_in,
    input  wire logic        cab_overheat_in,
    output var  logic        start_pulse_out,
    output var  logic        stop_pulse_out,
    output var  logic        run_enable_out,
    output var  logic        warn_out,
    output var  logic        breaker_close_missing_out,
    output var  logic        breaker_open_missing_out,
    output var  logic        breaker_halt_inhibited_out,
    output var  logic        irq_out
);
    // ---------------------------------------------------------------
    // reset image
    // ---------------------------------------------------------------
    localparam logic [`CNT_W-1:0] PULSE_DEF = `CNT_W'(`PULSE_DEF_MS / `TICK_MS);
    localparam logic [`CNT_W-1:0] DIS_DEF   = `CNT_W'(`DIS_STOP_DEF_MS / `TICK_MS);
    localparam logic [`CNT_W-1:0] OH_TICKS  = `CNT_W'(`OH_WARN_TICKS);

    localparam sup_state_t SUP_RESET = '{
        state:    BRK_OPEN,
        oh_mode:  OH_STOP,
        start_t:  PULSE_DEF,
        stop_t:   PULSE_DEF,
        on_dly:   PULSE_DEF,
        off_dly:  PULSE_DEF,
        dis_stop: DIS_DEF,
        mains_to: `CNT_W'(`MAINS_TO_DEF_S),
        p24_dly:  `CNT_W'(`P24_DLY_DEF_S),
        since_start: '1,
        since_stop:  '1,
        run_en:   1'b1,
        default:  '0
    };

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [`CNT_W-1:0] sat_inc(input logic [`CNT_W-1:0] v);
        sat_inc = (v == '1) ? v : v + `CNT_W'(1);
    endfunction

    function automatic logic [`CNT_W-1:0] sec_ticks(input logic [`CNT_W-1:0] s);
        sec_ticks = `CNT_W'(s * `TICKS_PER_S);
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a <= `OFF_IRQ_EN) && (a[1:0] == 2'b00);
    endfunction

    // ---------------------------------------------------------------
    // tick and pin synchronisers
    // ---------------------------------------------------------------
    logic             tick;
    logic [`SYNC_W-1:0] pins_sync;
    logic             mains;
    logic             p24_ok;
    logic             hot;

    tick_prescaler #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_tick (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .tick_out    (tick)
    );

    pin_sync u_sync (
        .core_clk_in (core_clk_in),
        .resetn_in   (resetn_in),
        .pins_in     ({cab_overheat_in, cab_24v_ok_in, mains_present_in}),
        .pins_out    (pins_sync)
    );

    assign mains  = pins_sync[0];
    assign p24_ok = pins_sync[1];
    assign hot    = pins_sync[2];

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    sup_state_t st_ff;
    sup_state_t nxt_st;

    always_comb begin
        logic              setup;
        logic              wr;
        logic [`EV_W-1:0]  ev;
        logic              brk_fault;
        logic [31:0]       rd;
        setup     = psel_in && !penable_in;
        wr        = psel_in && penable_in && pwrite_in && st_ff.pready;
        ev        = '0;
        brk_fault = 1'b0;
        rd        = 32'h0000_0000;
        nxt_st    = st_ff;

        // apb answers one cycle after setup, so pready is a flop
        nxt_st.pready  = setup;
        nxt_st.pslverr = setup && !addr_known(paddr_in);
        if (setup && !pwrite_in) begin
            if (paddr_in == `OFF_CFG) begin
                rd[`CFG_RESP_WARN]         = st_ff.resp_warn;
                rd[`CFG_OH_HI:`CFG_OH_LO]  = st_ff.oh_mode;
                rd[`CFG_P24_WARN]          = st_ff.p24_warn_only;
            end else if (paddr_in == `OFF_START_T) begin
                rd[`CNT_W-1:0] = st_ff.start_t;
            end else if (paddr_in == `OFF_STOP_T) begin
                rd[`CNT_W-1:0] = st_ff.stop_t;
            end else if (paddr_in == `OFF_ON_DLY) begin
                rd[`CNT_W-1:0] = st_ff.on_dly;
            end else if (paddr_in == `OFF_OFF_DLY) begin
                rd[`CNT_W-1:0] = st_ff.off_dly;
            end else if (paddr_in == `OFF_DIS_STOP) begin
                rd[`CNT_W-1:0] = st_ff.dis_stop;
            end else if (paddr_in == `OFF_MAINS_TO) begin
                rd[`CNT_W-1:0] = st_ff.mains_to;
            end else if (paddr_in == `OFF_P24_DLY) begin
                rd[`CNT_W-1:0] = st_ff.p24_dly;
            end else if (paddr_in == `OFF_STATUS) begin
                rd[3:0] = 4'(st_ff.state);
                rd[4]   = st_ff.close_missing;
                rd[5]   = st_ff.open_missing;
                rd[6]   = st_ff.halt_inhibited;
                rd[7]   = st_ff.app_stop;
                rd[8]   = st_ff.p24_lost;
                rd[9]   = st_ff.oh_seen;
                rd[10]  = st_ff.start_req;
                rd[11]  = st_ff.stop_req;
            end else if (paddr_in == `OFF_IRQ_STAT) begin
                rd[`EV_W-1:0] = st_ff.irq_stat;
            end else if (paddr_in == `OFF_IRQ_EN) begin
                rd[`EV_W-1:0] = st_ff.irq_en;
            end
            nxt_st.prdata = rd;
        end

        // register writes take effect on the completing access edge
        if (wr) begin
            if (paddr_in == `OFF_CTRL) begin
                if (pwdata_in[`CTRL_START]) nxt_st.start_req = 1'b1;
                if (pwdata_in[`CTRL_STOP])  nxt_st.stop_req  = 1'b1;
                if (pwdata_in[`CTRL_ACK])   nxt_st.app_stop  = 1'b0;
            end else if (paddr_in == `OFF_CFG) begin
                nxt_st.resp_warn     = pwdata_in[`CFG_RESP_WARN];
                nxt_st.oh_mode       = oh_mode_t'(pwdata_in[`CFG_OH_HI:`CFG_OH_LO]);
                nxt_st.p24_warn_only = pwdata_in[`CFG_P24_WARN];
            end else if (paddr_in == `OFF_START_T) begin
                nxt_st.start_t = pwdata_in[`CNT_W-1:0];
            end else if (paddr_in == `OFF_STOP_T) begin
                nxt_st.stop_t = pwdata_in[`CNT_W-1:0];
            end else if (paddr_in == `OFF_ON_DLY) begin
                nxt_st.on_dly = pwdata_in[`CNT_W-1:0];
            end else if (paddr_in == `OFF_OFF_DLY) begin
                nxt_st.off_dly = pwdata_in[`CNT_W-1:0];
            end else if (paddr_in == `OFF_DIS_STOP) begin
                nxt_st.dis_stop = pwdata_in[`CNT_W-1:0];
            end else if (paddr_in == `OFF_MAINS_TO) begin
                nxt_st.mains_to = pwdata_in[`CNT_W-1:0];
            end else if (paddr_in == `OFF_P24_DLY) begin
                nxt_st.p24_dly = pwdata_in[`CNT_W-1:0];
            end else if (paddr_in == `OFF_IRQ_CLR) begin
                nxt_st.irq_stat = st_ff.irq_stat & ~pwdata_in[`EV_W-1:0];
            end else if (paddr_in == `OFF_IRQ_EN) begin
                nxt_st.irq_en = pwdata_in[`EV_W-1:0];
            end
        end

        // spacing counters run in ticks and saturate
        if (tick) begin
            nxt_st.since_start = sat_inc(st_ff.since_start);
            nxt_st.since_stop  = sat_inc(st_ff.since_stop);
        end

        // ---------------------------------------------------------------
        // breaker sequencer
        // ---------------------------------------------------------------
        case (st_ff.state)
            BRK_OPEN: begin
                nxt_st.stop_req = 1'b0;            // already open
                if (st_ff.start_req && st_ff.since_stop >= st_ff.off_dly) begin
                    nxt_st.state         = BRK_START;
                    nxt_st.start_pulse   = 1'b1;
                    nxt_st.start_req     = 1'b0;
                    nxt_st.pulse_cnt     = '0;
                    nxt_st.mon_cnt       = '0;
                    nxt_st.since_start   = '0;
                    nxt_st.close_missing = 1'b0;
                    nxt_st.open_missing  = 1'b0;
                end
            end
            BRK_START: begin
                if (tick) begin
                    nxt_st.pulse_cnt = sat_inc(st_ff.pulse_cnt);
                    nxt_st.mon_cnt   = sat_inc(st_ff.mon_cnt);
                    if (sat_inc(st_ff.pulse_cnt) >= st_ff.start_t) begin
                        nxt_st.start_pulse = 1'b0;
                        nxt_st.state       = BRK_CLOSE_WAIT;
                    end
                end
            end
            BRK_CLOSE_WAIT: begin
                if (tick) nxt_st.mon_cnt = sat_inc(st_ff.mon_cnt);
                if (mains) begin
                    nxt_st.state = BRK_CLOSED;
                end else if (st_ff.mon_cnt >= sec_ticks(st_ff.mains_to)) begin
                    nxt_st.close_missing = 1'b1;
                    nxt_st.state         = BRK_OPEN;
                    ev[`EV_CLOSE_MISS]   = 1'b1;
                    brk_fault            = 1'b1;
                end
            end
            BRK_CLOSED: begin
                nxt_st.start_req = 1'b0;           // already closed
                // a stop request is held until both delays have run out
                if (st_ff.stop_req && st_ff.since_start >= st_ff.on_dly
                    && st_ff.since_start >= st_ff.dis_stop) begin
                    nxt_st.state         = BRK_STOP;
                    nxt_st.stop_pulse    = 1'b1;
                    nxt_st.stop_req      = 1'b0;
                    nxt_st.pulse_cnt     = '0;
                    nxt_st.mon_cnt       = '0;
                    nxt_st.since_stop    = '0;
                    nxt_st.close_missing = 1'b0;
                    nxt_st.open_missing  = 1'b0;
                end
            end
            BRK_STOP: begin
                if (tick) begin
                    nxt_st.pulse_cnt = sat_inc(st_ff.pulse_cnt);
                    nxt_st.mon_cnt   = sat_inc(st_ff.mon_cnt);
                    if (sat_inc(st_ff.pulse_cnt) >= st_ff.stop_t) begin
                        nxt_st.stop_pulse = 1'b0;
                        nxt_st.state      = BRK_OPEN_WAIT;
                    end
                end
            end
            BRK_OPEN_WAIT: begin
                if (tick) nxt_st.mon_cnt = sat_inc(st_ff.mon_cnt);
                if (!mains) begin
                    nxt_st.state = BRK_OPEN;
                end else if (st_ff.mon_cnt >= sec_ticks(st_ff.mains_to)) begin
                    nxt_st.open_missing = 1'b1;
                    nxt_st.state        = BRK_CLOSED;
                    ev[`EV_OPEN_MISS]   = 1'b1;
                    brk_fault           = 1'b1;
                end
            end
            default: begin
                nxt_st.state = BRK_OPEN;
            end
        endcase

        // stop-disabled shows while closed and the hold-off still runs
        nxt_st.halt_inhibited = (nxt_st.state == BRK_CLOSED)
                              && (nxt_st.since_start < st_ff.dis_stop);

        // ---------------------------------------------------------------
        // cabinet 24v supervision
        // ---------------------------------------------------------------
        nxt_st.p24_lost = !p24_ok;
        if (!p24_ok) begin
            if (!st_ff.p24_lost) ev[`EV_P24_WARN] = 1'b1;
            if (tick) nxt_st.p24_cnt = sat_inc(st_ff.p24_cnt);
            if (!st_ff.p24_warn_only && !st_ff.p24_done
                && st_ff.p24_cnt >= sec_ticks(st_ff.p24_dly)) begin
                ev[`EV_P24_ERR] = 1'b1;
                nxt_st.p24_done = 1'b1;
            end
        end else begin
            nxt_st.p24_cnt  = '0;
            nxt_st.p24_done = 1'b0;
        end

        // ---------------------------------------------------------------
        // cabinet overheat supervision
        // ---------------------------------------------------------------
        nxt_st.oh_seen = hot && (st_ff.oh_mode != OH_IGNORE);
        if (nxt_st.oh_seen) begin
            if (!st_ff.oh_seen && st_ff.oh_mode != OH_STOP) ev[`EV_OH_WARN] = 1'b1;
            if (tick) nxt_st.oh_cnt = sat_inc(st_ff.oh_cnt);
            if (!st_ff.oh_done && (st_ff.oh_mode == OH_STOP
                || (st_ff.oh_mode == OH_WARN_STOP && st_ff.oh_cnt >= OH_TICKS))) begin
                ev[`EV_OH_ERR] = 1'b1;
                nxt_st.oh_done = 1'b1;
            end
        end else begin
            nxt_st.oh_cnt  = '0;
            nxt_st.oh_done = 1'b0;
        end

        // ---------------------------------------------------------------
        // fault responses and interrupt
        // ---------------------------------------------------------------
        // error events win over a same-cycle acknowledge
        if ((brk_fault && !st_ff.resp_warn) || ev[`EV_P24_ERR] || ev[`EV_OH_ERR]) begin
            nxt_st.app_stop = 1'b1;
        end
        nxt_st.run_en   = !nxt_st.app_stop;
        nxt_st.warn     = nxt_st.p24_lost
                        || (nxt_st.oh_seen && st_ff.oh_mode != OH_STOP)
                        || nxt_st.close_missing || nxt_st.open_missing;
        nxt_st.irq_stat = nxt_st.irq_stat | ev;    // set beats clear
        nxt_st.irq      = |(nxt_st.irq_stat & nxt_st.irq_en);
    end

    always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_ff <= SUP_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ---------------------------------------------------------------
    // outputs, all from flops
    // ---------------------------------------------------------------
    assign prdata_out                 = st_ff.prdata;
    assign pready_out                 = st_ff.pready;
    assign pslverr_out                = st_ff.pslverr;
    assign start_pulse_out            = st_ff.start_pulse;
    assign stop_pulse_out             = st_ff.stop_pulse;
    assign run_enable_out             = st_ff.run_en;
    assign warn_out                   = st_ff.warn;
    assign breaker_close_missing_out  = st_ff.close_missing;
    assign breaker_open_missing_out   = st_ff.open_missing;
    assign breaker_halt_inhibited_out = st_ff.halt_inhibited;
    assign irq_out                    = st_ff.irq;
endmodule
`default_nettype wire

//--- sim/breaker_cabinet_supervisor_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module breaker_cabinet_supervisor_monitor (
    input wire logic       core_clk_in, resetn_in, psel_in, penable_in,
    input wire logic [7:0] paddr_in,
    input wire logic       pready_out, pslverr_out, cab_24v_ok_in, warn_out,
    input wire logic       start_pulse_out, stop_pulse_out, breaker_halt_inhibited_out,
    input wire logic       breaker_close_missing_out, breaker_open_missing_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!resetn_in);
    // the breaker pulses never overlap and a stop never cuts into a start
    a_pulses_apart: assert property ($rose(stop_pulse_out) |-> !$past(start_pulse_out))
        else $error("stop pulse overlaps start");
    a_stop_not_held: assert property ($rose(stop_pulse_out) |-> !breaker_halt_inhibited_out)
        else $error("stop while inhibited");
    a_close_miss_idle: assert property ($rose(breaker_close_missing_out) |-> !start_pulse_out)
        else $error("close fault during pulse");
    a_open_miss_idle: assert property ($rose(breaker_open_missing_out) |-> !stop_pulse_out)
        else $error("open fault during pulse");
    a_miss_cleared: assert property ($rose(start_pulse_out) |=> !breaker_close_missing_out)
        else $error("fault kept over new pulse");
    a_supply_warns: assert property (!cab_24v_ok_in [*6] |-> warn_out)
        else $error("no warning on supply loss");
    // one wait-free access cycle per transfer
    a_ready_next: assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("ready not one cycle");
    a_err_unmapped: assert property (pready_out && paddr_in > 8'h30 |-> pslverr_out)
        else $error("unmapped not refused");
    c_start: cover property ($rose(start_pulse_out));
    c_stop: cover property ($rose(stop_pulse_out));
    c_open_miss: cover property ($rose(breaker_open_missing_out));
endmodule
bind breaker_cabinet_supervisor breaker_cabinet_supervisor_monitor i_monitor (.*);
`default_nettype wire

//--- sim/cabinet_far_side.sv
`timescale 1ns/10ps
`default_nettype none
module cabinet_far_side (
    input  wire logic       core_clk_in,
    input  wire logic       start_in,
    input  wire logic       stop_in,
    input  wire logic       stuck_in,
    input  wire logic [2:0] dly_in,
    output var  logic       mains_out
);
    int n = 0;
    initial mains_out = 1'b0;
    // contacts move dly_in cycles into a pulse; a welded breaker never moves
    always @(posedge core_clk_in) begin
        n <= (start_in || stop_in) ? n + 1 : 0;
        if (n == dly_in && (start_in || stop_in) && !stuck_in)
            mains_out <= start_in;
    end
endmodule
`default_nettype wire

//--- sim/breaker_cabinet_supervisor_bench.sv
`timescale 1ns/10ps
`default_nettype none
module breaker_cabinet_supervisor_bench;
    logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0, stuck = 0, v24 = 1, hot = 0;
    logic        prdy, perr, re, mains, stp, spp, run, warn, cm, om, hi, irq;
    logic [2:0]  dly = 0;
    logic [7:0]  pa = 0;
    logic [31:0] pwd = 0, prd, rd;
    int          mismatches = 0, compares = 0, cyc = 0, seed = 37687, t, c;
    logic [7:0]  ra[9] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h30};
    logic [9:0]  rv[9] = '{10'h8, 10'h5, 10'h5, 10'h5, 10'h5, 10'h258, 10'h5, 10'h3, 10'h0};
    logic [7:0]  wv[9] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h1e, 8'h14, 8'h1, 8'h1, 8'h3f};
    breaker_cabinet_supervisor #(.TICK_CYCLES(10)) i_breaker_cabinet_supervisor (
        .core_clk_in(clk), .resetn_in(rstn), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(prdy), .pslverr_out(perr), .mains_present_in(mains),
        .cab_24v_ok_in(v24), .cab_overheat_in(hot), .start_pulse_out(stp),
        .stop_pulse_out(spp), .run_enable_out(run), .warn_out(warn),
        .breaker_close_missing_out(cm), .breaker_open_missing_out(om),
        .breaker_halt_inhibited_out(hi), .irq_out(irq));
    cabinet_far_side i_cabinet_far_side (.core_clk_in(clk), .start_in(stp), .stop_in(spp),
        .stuck_in(stuck), .dly_in(dly), .mains_out(mains));
    initial forever #4 clk = ~clk;
    // cycle count doubles as the hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 70000) begin
            mismatches++;
            wrap_up;
        end
    end
    task automatic wrap_up;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, entered right after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        re = perr;
        psel <= 0;
        pen <= 0;
        @(posedge clk);
    endtask
    task automatic wt(ref logic s, input logic v);
        while (s !== v) @(posedge clk);
    endtask
    function automatic logic [31:0] inside_span(int n, int lo, int hi);
        return 32'(n >= lo && n <= hi);
    endfunction
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1;
        for (int i = 0; i < 9; i++) begin
            bus(1'b0, ra[i], 32'h0);
            check(rd, 32'(rv[i]));
        end
        bus(1'b0, 8'h34, 32'h0);
        check({rd[30:0], re}, 32'h1);
        t = 2 + ($random(seed) & 3);
        dly <= 3'($random(seed));
        for (int i = 1; i < 9; i++) bus(1'b1, ra[i], i < 4 ? t : 32'(wv[i]));
        bus(1'b1, 8'h00, 32'h1);
        wt(stp, 1'b1);
        c = cyc;
        wt(stp, 1'b0);
        check(inside_span(cyc - c, t * 10 - 10, t * 10 + 1), 32'h1);
        bus(1'b1, 8'h00, 32'h2);
        check(32'(hi), 32'h1);
        stuck <= 1;
        wt(spp, 1'b1);
        check(32'(cyc - c >= 190), 32'h1);
        c = cyc;
        wt(om, 1'b1);
        check(inside_span(cyc - c, 90, 112), 32'h1);
        bus(1'b0, 8'h28, 32'h0);
        check({rd[29:0], run, irq}, 32'h9);
        bus(1'b1, 8'h2c, 32'h2);
        bus(1'b1, 8'h00, 32'h4);
        check(32'({irq, run}), 32'h1);
        stuck <= 0;
        bus(1'b1, 8'h00, 32'h2);
        wt(spp, 1'b1);
        c = cyc;
        wt(spp, 1'b0);
        bus(1'b1, 8'h04, 32'h9);
        stuck <= 1;
        bus(1'b1, 8'h00, 32'h1);
        wt(stp, 1'b1);
        check(inside_span(cyc - c, 290, 302), 32'h1);
        c = cyc;
        wt(cm, 1'b1);
        check(inside_span(cyc - c, 90, 112) & 32'(run), 32'h1);
        bus(1'b1, 8'h2c, 32'h3f);
        v24 <= 0;
        c = cyc;
        repeat (8) @(posedge clk);
        bus(1'b0, 8'h28, 32'h0);
        check(rd, 32'h4);
        wt(run, 1'b0);
        check(inside_span(cyc - c, 95, 115), 32'h1);
        v24 <= 1;
        bus(1'b1, 8'h00, 32'h4);
        hot <= 1;
        repeat (8) @(posedge clk);
        check(32'(run), 32'h0);
        hot <= 0;
        bus(1'b1, 8'h04, 32'hc);
        bus(1'b1, 8'h00, 32'h4);
        hot <= 1;
        c = cyc;
        wt(run, 1'b0);
        check(inside_span(cyc - c, 59990, 60020), 32'h1);
        wrap_up;
    end
endmodule
`default_nettype wire
